// ===== dv/hpb_host_model.sv
`timescale 1ns/1ps
// Host bus master. It moves its pins only on bus clock edges and samples the target on rising edges.
module hpb_host_model (
  // Bus side.
  input  wire logic        pci_clk_i,
  input  wire logic [31:0] ad_i,
  input  wire logic        trdy_n_i,
  input  wire logic        devsel_n_i,
  input  wire logic        stop_n_i,
  output logic             frame_n_o = 1'b1,
  output logic             irdy_n_o  = 1'b1,
  output logic [3:0]       cbe_n_o   = 4'hf,
  output logic [31:0]      ad_o      = 32'h0,
  output logic             ad_oe_o   = 1'b0
);
  logic [31:0] wq[$];
  logic [31:0] rq[$];

  // Released data lines keep changing, so a stale word is never taken for fresh data.
  always @(negedge pci_clk_i) begin
    if (!ad_oe_o) begin
      ad_o <= ~ad_o;
    end
  end

  // One transaction of nw words; got counts words moved, or -1 when no target claims it.
  task automatic xfer(input logic [31:0] addr, input logic [3:0] cmd, input int nw, output int got);
    int wt;
    got = 0;
    wt  = 0;
    @(posedge pci_clk_i);
    frame_n_o <= 1'b0;
    cbe_n_o   <= cmd;
    ad_o      <= addr;
    ad_oe_o   <= 1'b1;
    @(posedge pci_clk_i);
    frame_n_o <= (nw == 1);
    irdy_n_o  <= 1'b0;
    cbe_n_o   <= 4'h0;
    ad_oe_o   <= cmd[0];
    if (cmd[0]) ad_o <= wq[0];
    while (got < nw && wt < 60) begin
      @(posedge pci_clk_i);
      wt++;
      if (devsel_n_i && wt > 5) begin
        got = -1;
        break;
      end
      if (!trdy_n_i) begin
        if (cmd[0]) void'(wq.pop_front());
        else rq.push_back(ad_i);
        got++;
        frame_n_o <= (got >= nw - 1);
        if (cmd[0] && wq.size() > 0) ad_o <= wq[0];
      end
      if (!stop_n_i) break;
    end
    // A retry or disconnect leaves FRAME low: lift it first, then IRDY one edge later.
    if (!frame_n_o) begin
      frame_n_o <= 1'b1;
      @(posedge pci_clk_i);
    end
    irdy_n_o <= 1'b1;
    ad_oe_o  <= 1'b0;
    cbe_n_o  <= ~cbe_n_o;
    repeat (2) @(posedge pci_clk_i);
  endtask : xfer
endmodule : hpb_host_model

// ===== dv/hpb_host_port_tb.sv
`timescale 1ns/1ps
// Bench: a bus master on one side, a stalling memory and a reference image on the other.
module hpb_host_port_tb;
  import hpb_pkg::*;

  logic        ref_clk   = 1'b0;
  logic        pci_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  base      = 8'h84;
  logic [3:0]  win_en    = 4'h3;
  logic [1:0]  size      = 2'h2;
  logic        vga_en    = 1'b0;
  logic [5:0]  vga_bank  = 6'h15;
  logic        mem_ready = 1'b0;
  logic        rvalid    = 1'b0;
  logic [31:0] rdata     = 32'h0;
  logic        hold      = 1'b0;
  logic        frame_n, irdy_n, ad_oe, m_oe, trdy_n, trdy_oe, devsel_n, devsel_oe, stop_n, stop_oe, mem_valid;
  logic [3:0]  cbe_n, wq_level;
  logic [31:0] ad_w, ad_d, ad_m;
  logic [19:0] rd_a;
  // After reset the block treats page zero as the page last issued.
  logic [19:0] prev_wa   = 20'h0;
  logic [3:0]  rd_cmd[3] = '{CMD_MRD, CMD_MRM, CMD_MRL};
  logic [3:0]  bad[4]    = '{4'h2, 4'h3, 4'ha, 4'hb};
  hpb_req_s    mem_req;
  hpb_req_s    got_q[$];
  hpb_req_s    exp_q[$];
  logic [31:0] mem[int];
  logic [31:0] img[int];
  int          rd_wait = 0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          last_got;

  // Clocks; the bus clock starts off phase so its edges never meet the block clock's.
  always #5 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #40 pci_clk = ~pci_clk;
  end

  // Shared lines: the enabled party drives, released strobes are pulled high.
  assign ad_w = ad_oe ? ad_d : ad_m;
  wire t_w = trdy_oe ? trdy_n : 1'b1;
  wire d_w = devsel_oe ? devsel_n : 1'b1;
  wire s_w = stop_oe ? stop_n : 1'b1;

  hpb_host_port DUT (.ref_clk_i(ref_clk), .rst_i(rst), .pci_clk_i(pci_clk), .frame_n_i(frame_n),
    .irdy_n_i(irdy_n), .cbe_n_i(cbe_n), .ad_i(ad_w), .ad_o(ad_d), .ad_oe_o(ad_oe), .trdy_n_o(trdy_n),
    .trdy_oe_o(trdy_oe), .devsel_n_o(devsel_n), .devsel_oe_o(devsel_oe), .stop_n_o(stop_n),
    .stop_oe_o(stop_oe), .display_memory_base_reg_i(base), .linear_window_enable_field_i(win_en),
    .mem_size_i(size), .vga_enable_i(vga_en), .vga_bank_i(vga_bank), .mem_valid_o(mem_valid),
    .mem_ready_i(mem_ready), .mem_req_o(mem_req), .mem_rvalid_i(rvalid), .mem_rdata_i(rdata),
    .wq_level_o(wq_level));

  hpb_host_model HOST (.pci_clk_i(pci_clk), .ad_i(ad_w), .trdy_n_i(t_w), .devsel_n_i(d_w),
    .stop_n_i(s_w), .frame_n_o(frame_n), .irdy_n_o(irdy_n), .cbe_n_o(cbe_n), .ad_o(ad_m), .ad_oe_o(m_oe));

  // Memory: random stalls, reads answered a few cycles later, noise on the data lines otherwise.
  always @(posedge ref_clk) begin
    mem_ready <= !hold && ($urandom_range(3) != 0);
    rvalid    <= (rd_wait == 1);
    rdata     <= (rd_wait == 1 && mem.exists(rd_a)) ? mem[rd_a] : $urandom;
    if (rd_wait > 0) rd_wait <= rd_wait - 1;
    // Host and block must never drive the shared data lines together.
    chk({31'h0, ad_oe & m_oe}, 32'h0);
    if (mem_valid && mem_ready && !rst) begin
      got_q.push_back(mem_req);
      if (mem_req.we) begin
        mem[mem_req.waddr] = mem_req.data;
      end else begin
        rd_a    <= mem_req.waddr;
        rd_wait <= 2 + $urandom_range(4);
      end
    end
  end

  function automatic logic [31:0] swp(logic [1:0] ap, logic [31:0] d);
    case (ap)
      2'h1: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      2'h2: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      2'h3: return {d[15:0], d[31:16]};
      default: return d;
    endcase
  endfunction : swp

  // Word address of the k-th word; the linear window wraps at the installed size.
  function automatic logic [19:0] wmap(logic [31:0] a, int k);
    logic [19:0] w;
    w = ((a[31:16] == VGA_SEG) ? {vga_bank, a[15:2]} : a[21:2]) + 20'(k);
    if (a[31:16] != VGA_SEG) w = w & ((size == 2'h0) ? MASK_1M : (size == 2'h1) ? MASK_2M : MASK_4M);
    return w;
  endfunction : wmap

  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_req(hpb_req_s g, hpb_req_s e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: request %h expected %h", $time, g, e);
    end
  endtask : chk_req

  // One bus transaction; memory traffic and read data are predicted from the reference image.
  task automatic op(logic [31:0] a, logic [3:0] cmd, int n, int expn);
    int          got;
    logic [1:0]  ap;
    logic [31:0] sq[$];
    hpb_req_s    e;
    ap = (a[31:16] == VGA_SEG) ? 2'h0 : a[23:22];
    for (int i = 0; i < n; i++) sq.push_back($urandom);
    HOST.wq = sq;
    HOST.xfer(a, cmd, n, got);
    if (expn != -2) chk(32'(got), 32'(expn));
    last_got = got;
    for (int i = 0; i < got; i++) begin
      e = '0;
      e.we = cmd[0];
      e.waddr = wmap(a, i);
      if (cmd[0]) begin
        e.data = swp(ap, sq[i]);
        img[e.waddr] = e.data;
      end else begin
        chk(HOST.rq.pop_front(), swp(ap, img[e.waddr]));
      end
      exp_q.push_back(e);
    end
  endtask : op

  // Lets the memory side go quiet, then compares every request in arrival order.
  task automatic drain_check();
    hpb_req_s e;
    hpb_req_s g;
    for (int t = 0; t < 3000 && (got_q.size() < exp_q.size() || mem_valid); t++) @(posedge ref_clk);
    chk(32'(got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      e = exp_q.pop_front();
      g = got_q.pop_front();
      e.page = (e.waddr[19:PAGE_LSB] == prev_wa[19:PAGE_LSB]);
      // The host enables every byte lane and reads always fetch the whole word.
      e.be = 4'hf;
      prev_wa = e.waddr;
      if (!g.we) g.data = '0;
      chk_req(g, e);
    end
    exp_q.delete();
    got_q.delete();
  endtask : drain_check

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well past the expected run time.
  initial begin
    #800us;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    logic [31:0] a;
    void'($urandom(32'hcaa9));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({28'h0, wq_level}, 32'h0);
    chk({31'h0, mem_valid}, 32'h0);
    // Every size and aperture; the first two words of each write are read back at once through the next aperture.
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk);
      size <= 2'(s);
      for (int ap = 0; ap < 4; ap++) begin
        a = {base, 2'(ap), 22'($urandom) & 22'h3fffc0};
        op(a, ap[0] ? CMD_MWI : CMD_MWR, 3, 3);
        a[23:22] = 2'(ap + 1);
        op(a, rd_cmd[ap % 3], 2, 2);
      end
      drain_check();
    end
    // Memory stalls while a long burst fills the queue; the next write is turned away.
    @(posedge ref_clk);
    hold <= 1'b1;
    a = {base, 24'h000100};
    op(a, CMD_MWI, 12, -2);
    chk(32'(last_got >= 8 && last_got < 12), 32'h1);
    chk({28'h0, wq_level}, 32'h8);
    op(a, CMD_MWR, 1, 0);
    @(posedge ref_clk);
    hold <= 1'b0;
    drain_check();
    // Misses: wrong top byte, window switched off, commands that are not memory cycles.
    op({base + 8'h1, 24'h000040}, CMD_MWR, 1, -1);
    @(posedge ref_clk);
    win_en <= 4'h0;
    op({base, 24'h000040}, CMD_MWR, 1, -1);
    @(posedge ref_clk);
    win_en <= 4'h8;
    foreach (bad[i]) op({base, 24'h000040}, bad[i], 1, -1);
    // Legacy segment window, then the same address with it switched off.
    @(posedge ref_clk);
    vga_en   <= 1'b1;
    vga_bank <= 6'($urandom);
    a = {VGA_SEG, 16'h8100};
    @(posedge ref_clk);
    op(a, CMD_MWR, 2, 2);
    op(a, CMD_MRD, 2, 2);
    @(posedge ref_clk);
    vga_en <= 1'b0;
    op(a, CMD_MWR, 1, -1);
    drain_check();
    report_and_stop();
  end
endmodule : hpb_host_port_tb

// ===== rtl/hpb_host_port.sv
`timescale 1ns/1ps
// What this block does
// R1 - Attaches straight to the bus pins as a conforming target, no glue logic.
// R2 - Completes 32-bit memory transactions at bus clock rates up to 33 MHz.
// R3 - Accepts long memory bursts, advancing the address every data phase.
// R4 - Four apertures, each with its own byte-order swap for host data.
// R5 - Linear mode maps memory as one byte range of 1, 2 or 4 Mbytes.
// R6 - Linear hit needs top address byte equal base and nonzero enable field.
// R7 - Decodes the full 32-bit address itself.
// R8 - Also serves the legacy 64-Kbyte segment window.
// R9 - Posts writes and ends the bus phase once address and data are caught.
// R10 - Write queue holds eight 32-bit entries in every display mode.
// R11 - Drains queued writes whenever the two-entry memory buffer has room, flagging same-page entries.
// R12 - A full queue retries or disconnects writes; drain keeps arrival order.
// R13 - Reads return only after all earlier queued writes are committed.
module hpb_host_port (
  // Clock and reset.
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Bus pins.
  input  wire logic              pci_clk_i,
  input  wire logic              frame_n_i,
  input  wire logic              irdy_n_i,
  input  wire logic [3:0]        cbe_n_i,
  input  wire logic [31:0]       ad_i,
  output logic      [31:0]       ad_o,
  output logic                   ad_oe_o,
  output logic                   trdy_n_o,
  output logic                   trdy_oe_o,
  output logic                   devsel_n_o,
  output logic                   devsel_oe_o,
  output logic                   stop_n_o,
  output logic                   stop_oe_o,
  // Configuration levels.
  input  wire logic [7:0]        display_memory_base_reg_i,
  input  wire logic [3:0]        linear_window_enable_field_i,
  input  wire logic [1:0]        mem_size_i,
  input  wire logic              vga_enable_i,
  input  wire logic [5:0]        vga_bank_i,
  // Display memory port.
  output logic                   mem_valid_o,
  input  wire logic              mem_ready_i,
  output hpb_pkg::hpb_req_s      mem_req_o,
  input  wire logic              mem_rvalid_i,
  input  wire logic [31:0]       mem_rdata_i,
  output logic      [3:0]        wq_level_o
);
  import hpb_pkg::*;

  // Reorders bytes for an aperture; each mode is its own inverse.
  function automatic logic [31:0] swap32(input logic [31:0] d, input logic [1:0] ap);
    case (ap)
      AP_HALF: swap32 = {d[23:16], d[31:24], d[7:0], d[15:8]};
      AP_FULL: swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
      AP_WORD: swap32 = {d[15:0], d[31:16]};
      default: swap32 = d;
    endcase
  endfunction : swap32

  hpb_pin_s   pin_w;
  hpb_pin_s   sync1_r;
  hpb_pin_s   sync2_r;
  hpb_pin_s   prev_r;
  hpb_state_e state_r;
  hpb_state_e state_nxt;
  logic [19:0] addr_r;
  logic [19:0] addr_nxt;
  logic [1:0]  ap_r;
  logic [1:0]  ap_nxt;
  logic        trdy_n_r;
  logic        trdy_nxt;
  logic        devsel_n_r;
  logic        devsel_nxt;
  logic        stop_n_r;
  logic        stop_nxt;
  logic        ctl_oe_r;
  logic        oe_nxt;
  logic [31:0] ad_r;
  logic        rd_sent_r;
  logic        rd_have_r;
  hpb_req_s    wq_mem_r [WQ_DEPTH];
  logic [2:0]  wq_wp_r;
  logic [2:0]  wq_rp_r;
  logic [3:0]  wq_cnt_r;
  hpb_req_s    buf_mem_r [BUF_DEPTH];
  logic        buf_wp_r;
  logic        buf_rp_r;
  logic [1:0]  buf_cnt_r;
  logic [19:PAGE_LSB] last_page_r;
  hpb_req_s    bin_w;
  logic [19:0] size_mask_w;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Every pin passes two flops; a third stage holds the value seen just before each link edge.
  assign pin_w = '{clk: pci_clk_i, frame_n: frame_n_i, irdy_n: irdy_n_i, cbe_n: cbe_n_i, ad: ad_i};
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
      prev_r  <= PIN_RST;
    end else begin
      sync1_r <= pin_w;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Address phase decode on the full address.
  wire       pedge_w   = sync2_r.clk & ~prev_r.clk;
  wire [3:0] cmd_w     = prev_r.cbe_n; // The command code stands on these pins as driven, not inverted.
  wire       cmd_rd_w  = (cmd_w == CMD_MRD) | (cmd_w == CMD_MRM) | (cmd_w == CMD_MRL); // see R2
  wire       cmd_wr_w  = (cmd_w == CMD_MWR) | (cmd_w == CMD_MWI); // see R2
  wire       lin_hit_w = (prev_r.ad[31:24] == display_memory_base_reg_i)
                         && (linear_window_enable_field_i != 4'h0); // see R6 see R7
  wire       vga_hit_w = vga_enable_i && (prev_r.ad[31:16] == VGA_SEG); // see R8 see R7
  wire       addr_ph_w = pedge_w && !prev_r.frame_n && (state_r == S_IDLE);
  wire       claim_w   = addr_ph_w && (lin_hit_w | vga_hit_w) && (cmd_rd_w | cmd_wr_w);
  wire [19:0] start_w  = lin_hit_w ? prev_r.ad[21:2] : {vga_bank_i, prev_r.ad[15:2]}; // see R5 see R8
  wire       xfer_w    = pedge_w && !prev_r.irdy_n && !trdy_n_r;
  wire       push_w    = xfer_w && (state_r == S_WDATA); // see R9
  wire       rd_xfer_w = xfer_w && (state_r == S_RDATA);
  wire       full_nxt_w = (wq_cnt_r == 4'(WQ_DEPTH)) || ((wq_cnt_r == 4'(WQ_DEPTH - 1)) && push_w);
  wire       rd_issue_w = (state_r == S_RWAIT) && !rd_sent_r && (wq_cnt_r == 4'h0)
                          && (buf_cnt_r == 2'h0); // see R13

  // Target sequencer; pin outputs change only at detected link edges.
  always_comb begin
    state_nxt  = state_r;
    trdy_nxt   = trdy_n_r;
    devsel_nxt = devsel_n_r;
    stop_nxt   = stop_n_r;
    oe_nxt     = ctl_oe_r;
    addr_nxt   = xfer_w ? addr_r + 20'h1 : addr_r; // see R3
    ap_nxt     = ap_r;
    case (state_r)
      S_IDLE: begin
        if (claim_w) begin
          devsel_nxt = 1'b0;
          oe_nxt     = 1'b1;
          addr_nxt   = start_w;
          ap_nxt     = lin_hit_w ? prev_r.ad[23:22] : AP_NONE; // see R4
          if (cmd_rd_w) begin
            state_nxt = S_RWAIT;
          end else if (wq_cnt_r == 4'(WQ_DEPTH)) begin
            stop_nxt  = 1'b0; // see R12
            state_nxt = S_BACKOFF;
          end else begin
            trdy_nxt  = 1'b0;
            state_nxt = S_WDATA;
          end
        end else if (addr_ph_w) begin
          state_nxt = S_SKIP;
        end
      end
      S_WDATA: begin
        if (push_w && prev_r.frame_n) begin
          trdy_nxt   = 1'b1;
          devsel_nxt = 1'b1;
          state_nxt  = S_TURN;
        end else if (pedge_w && full_nxt_w) begin
          trdy_nxt  = 1'b1;
          stop_nxt  = 1'b0; // see R12
          state_nxt = S_BACKOFF;
        end
      end
      S_BACKOFF: begin
        if (pedge_w && prev_r.frame_n) begin
          stop_nxt   = 1'b1;
          devsel_nxt = 1'b1;
          state_nxt  = S_TURN;
        end
      end
      S_RWAIT: begin
        if (pedge_w && rd_have_r) begin
          trdy_nxt  = 1'b0;
          state_nxt = S_RDATA;
        end
      end
      S_RDATA: begin
        if (rd_xfer_w) begin
          trdy_nxt   = 1'b1;
          devsel_nxt = prev_r.frame_n;
          state_nxt  = prev_r.frame_n ? S_TURN : S_RWAIT; // see R3
        end
      end
      S_TURN: begin
        if (pedge_w) begin
          oe_nxt    = 1'b0; // see R1
          state_nxt = S_IDLE;
        end
      end
      S_SKIP: begin
        if (pedge_w && prev_r.frame_n && prev_r.irdy_n) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Sequencer state and pin drivers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r    <= S_IDLE;
      addr_r     <= 20'h0;
      ap_r       <= AP_NONE;
      trdy_n_r   <= 1'b1;
      devsel_n_r <= 1'b1;
      stop_n_r   <= 1'b1;
      ctl_oe_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      addr_r     <= addr_nxt;
      ap_r       <= ap_nxt;
      trdy_n_r   <= trdy_nxt;
      devsel_n_r <= devsel_nxt;
      stop_n_r   <= stop_nxt;
      ctl_oe_r   <= oe_nxt;
    end
  end

  // Read tracking: one memory read per data phase, data swapped back for the host.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_sent_r <= 1'b0;
      rd_have_r <= 1'b0;
      ad_r      <= 32'h0;
    end else begin
      rd_sent_r <= rd_issue_w | (rd_sent_r & (state_r == S_RWAIT));
      rd_have_r <= (mem_rvalid_i & rd_sent_r & (state_r == S_RWAIT)) | (rd_have_r & (state_r == S_RWAIT));
      if (mem_rvalid_i && rd_sent_r && !rd_have_r) begin
        ad_r <= swap32(mem_rdata_i, ap_r); // see R4
      end
    end
  end

  assign ad_o        = ad_r;
  assign ad_oe_o     = (state_r == S_RWAIT) | (state_r == S_RDATA);
  assign trdy_n_o    = trdy_n_r;
  assign devsel_n_o  = devsel_n_r;
  assign stop_n_o    = stop_n_r;
  assign trdy_oe_o   = ctl_oe_r;
  assign devsel_oe_o = ctl_oe_r;
  assign stop_oe_o   = ctl_oe_r;

  // Posted write queue; the bus phase ends as soon as the entry is stored.
  wire [31:0] wr_be_x_w = swap32({{8{~prev_r.cbe_n[3]}}, {8{~prev_r.cbe_n[2]}},
                                  {8{~prev_r.cbe_n[1]}}, {8{~prev_r.cbe_n[0]}}}, ap_r);
  wire hpb_req_s wr_req_w = '{we: 1'b1, page: 1'b0, waddr: addr_r, data: swap32(prev_r.ad, ap_r),
                              be: {wr_be_x_w[24], wr_be_x_w[16], wr_be_x_w[8], wr_be_x_w[0]}}; // see R4
  wire hpb_req_s rd_req_w = '{we: 1'b0, page: 1'b0, waddr: addr_r, data: 32'h0, be: 4'hf};
  wire       buf_rdy_w = (buf_cnt_r != 2'(BUF_DEPTH));
  wire       wq_pop_w  = (wq_cnt_r != 4'h0) && buf_rdy_w; // see R11
  wire       bin_vld_w = (wq_cnt_r != 4'h0) | rd_issue_w;
  wire       bpush_w   = bin_vld_w && buf_rdy_w;
  wire       bpop_w    = mem_valid_o && mem_ready_i;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wq_wp_r  <= 3'h0;
      wq_rp_r  <= 3'h0;
      wq_cnt_r <= 4'h0;
    end else begin
      if (push_w) begin
        wq_mem_r[wq_wp_r] <= wr_req_w; // see R10
        wq_wp_r           <= wq_wp_r + 3'h1;
      end
      if (wq_pop_w) begin
        wq_rp_r <= wq_rp_r + 3'h1; // see R12
      end
      wq_cnt_r <= wq_cnt_r + {3'h0, push_w} - {3'h0, wq_pop_w};
    end
  end

  // Installed size wraps linear offsets; page flag marks entries in the page last issued.
  assign size_mask_w = (mem_size_i == SZ_1M) ? MASK_1M : (mem_size_i == SZ_2M) ? MASK_2M : MASK_4M;
  always_comb begin
    bin_w       = (wq_cnt_r != 4'h0) ? wq_mem_r[wq_rp_r] : rd_req_w;
    bin_w.waddr = bin_w.waddr & size_mask_w; // see R5
    bin_w.page  = (bin_w.waddr[19:PAGE_LSB] == last_page_r); // see R11
  end

  // Two-entry buffer toward memory so a stalled memory port loses nothing.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem_r[i] <= REQ_RST;
      end
      buf_wp_r    <= 1'b0;
      buf_rp_r    <= 1'b0;
      buf_cnt_r   <= 2'h0;
      last_page_r <= '0;
    end else begin
      if (bpush_w) begin
        buf_mem_r[buf_wp_r] <= bin_w;
        buf_wp_r            <= ~buf_wp_r;
        last_page_r         <= bin_w.waddr[19:PAGE_LSB];
      end
      if (bpop_w) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, bpush_w} - {1'b0, bpop_w};
    end
  end

  assign mem_valid_o = (buf_cnt_r != 2'h0);
  assign mem_req_o   = buf_mem_r[buf_rp_r];
  assign wq_level_o  = wq_cnt_r;

  // Checks on the queue, decode and burst behaviour.
  chk_queue_bound: assert property (wq_cnt_r <= 4'(WQ_DEPTH)) // see R10
    else $error("write queue above eight entries");
  chk_full_no_push: assert property ((wq_cnt_r == 4'(WQ_DEPTH)) |-> !push_w) // see R12
    else $error("write taken while queue full");
  chk_post_release: assert property (push_w && prev_r.frame_n |=> state_r == S_TURN && devsel_n_o) // see R9
    else $error("posted write did not release the bus");
  chk_read_ordered: assert property (mem_valid_o && !mem_req_o.we |-> wq_cnt_r == 4'h0) // see R13
    else $error("read issued ahead of queued writes");
  chk_linear_miss: assert property (addr_ph_w && linear_window_enable_field_i == 4'h0 && !vga_hit_w
                                    |=> state_r == S_SKIP) // see R6
    else $error("claimed with linear window disabled");
  chk_burst_step: assert property (xfer_w && !prev_r.frame_n |=> addr_r == $past(addr_r) + 20'h1) // see R3
    else $error("burst address did not advance");
  chk_mem_hold: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_req_o)) // see R11
    else $error("memory request changed while stalled");
  chk_size_wrap: assert property (mem_valid_o |-> (mem_req_o.waddr & ~size_mask_w) == 20'h0) // see R5
    else $error("memory address beyond installed size");
  chk_turn_release: assert property (state_r == S_TURN && pedge_w |=> state_r == S_IDLE && !ctl_oe_r) // see R1
    else $error("control pins not released after turnaround");

  cov_backoff:  cover property (state_r == S_BACKOFF);
  cov_full:     cover property (wq_cnt_r == 4'(WQ_DEPTH));
  cov_read:     cover property (rd_xfer_w);
  cov_burst:    cover property (push_w ##[1:40] push_w);

endmodule : hpb_host_port

// ===== shared/hpb_pkg.sv
package hpb_pkg;

  // Queue and buffer sizes.
  localparam int WQ_DEPTH  = 8;
  localparam int BUF_DEPTH = 2;
  // Word address bit where a display-memory page starts (2-Kbyte pages).
  localparam int PAGE_LSB  = 9;

  // Bus commands as seen on the byte-enable pins during the address phase.
  localparam logic [3:0] CMD_MRD = 4'h6;
  localparam logic [3:0] CMD_MWR = 4'h7;
  localparam logic [3:0] CMD_MRM = 4'hc;
  localparam logic [3:0] CMD_MRL = 4'he;
  localparam logic [3:0] CMD_MWI = 4'hf;

  // Upper half of a legacy 64-Kbyte segment address.
  localparam logic [15:0] VGA_SEG = 16'h000a;

  // Word address masks for the installed memory size.
  localparam logic [19:0] MASK_1M = 20'h3ffff;
  localparam logic [19:0] MASK_2M = 20'h7ffff;
  localparam logic [19:0] MASK_4M = 20'hfffff;

  typedef enum logic [1:0] {SZ_1M = 2'h0, SZ_2M = 2'h1, SZ_4M = 2'h2} hpb_size_e;

  // Byte order of each aperture.
  typedef enum logic [1:0] {AP_NONE = 2'h0, AP_HALF = 2'h1, AP_FULL = 2'h2, AP_WORD = 2'h3} hpb_ap_e;

  typedef enum logic [6:0] {
    S_IDLE    = 7'h01,
    S_WDATA   = 7'h02,
    S_BACKOFF = 7'h04,
    S_RWAIT   = 7'h08,
    S_RDATA   = 7'h10,
    S_TURN    = 7'h20,
    S_SKIP    = 7'h40
  } hpb_state_e;

  typedef struct packed {
    logic        clk;
    logic        frame_n;
    logic        irdy_n;
    logic [3:0]  cbe_n;
    logic [31:0] ad;
  } hpb_pin_s;

  typedef struct packed {
    logic        we;
    logic        page;
    logic [19:0] waddr;
    logic [31:0] data;
    logic [3:0]  be;
  } hpb_req_s;

  localparam hpb_pin_s PIN_RST = '{clk: 1'b0, frame_n: 1'b1, irdy_n: 1'b1, cbe_n: 4'hf, ad: 32'h0};
  localparam hpb_req_s REQ_RST = '0;

endpackage : hpb_pkg
